// file: smtx_regs.svh
// register map, field positions and timing constants of the smbus extension block
// Overview of operation
// - fast ack off: ack choice applies to next byte; on: write after byte sends it
// - alert response address matches only while alert_response_enable is set
// - second address matches only while second_address_enable (bit 5) is set
// - timeout counter ticks at module clock / 64, or undivided when select is 1
// - clock low flag sets when value nonzero and scl low past it; write 1 clears
// - low timeout detection is off while the 16-bit value is zero
// - read-only bus idle flag: scl and sda high beyond value / 512; clears itself
// - clock high data low flag: scl high, sda low beyond value / 512; write 1 clears
// - clock high data low interrupt while its enable (bit 0) is 1, or while its status bit 1 is unmasked
// - second address field in bits 7 to 1; bit 0 reads zero
// - 16-bit low timeout value: high byte register 15:8, low byte register 7:0
`ifndef SMTX_REGS_SVH
`define SMTX_REGS_SVH
// register indices; byte address is four times the index
`define SMTX_IDX_CTRL 16'h3078
`define SMTX_IDX_A2 16'h3079
`define SMTX_IDX_SLTH 16'h307A
`define SMTX_IDX_SLTL 16'h307B
`define SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL 16'h307C
`define SMTX_IDX_IRQST 16'h307D
`define SMTX_IDX_IRQMSK 16'h307E
// control and status fields
`define SMTX_B_FAST_ACK_MODE 7
`define SMTX_B_ALERT_RESPONSE_ENABLE 6
`define SMTX_B_A2EN 5
`define SMTX_B_TIMEOUT_CLOCK_SELECT 4
`define SMTX_B_CLOCK_LOW_TIMEOUT_FLAG 3
`define SMTX_B_BUS_IDLE_TIMEOUT_FLAG 2
`define SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG 1
`define SMTX_B_CLOCK_HIGH_DATA_LOW_IRQ_ENABLE 0
// interrupt status fields
`define SMTX_IRQ_LOW 0
`define SMTX_IRQ_HL 1
`define SMTX_IRQ_IDLE 2
// reset values
`define SMTX_RST_BYTE 8'h00
`define SMTX_RST_IRQ 3'h0
// smbus alert response address, 7 bits
`define SMTX_ALERT_ADDR 7'h0C
// timing
`define SMTX_PRESCALE 64
`define SMTX_HIGH_SHIFT 9
`endif

// file: smtx_pkg.sv
// shared types of the smbus extension block
package smtx_pkg;
  // fast acknowledge sequencing
  typedef enum logic [0:0] {SMTX_ACK_IDLE, SMTX_ACK_WAIT} smtx_ack_state_type;
endpackage : smtx_pkg

// file: smtx_tick_gen.sv
// timeout counter clock: module clock or module clock divided down
`timescale 1ns/1ps
`default_nettype none
module smtx_tick_gen #(
  parameter int DIV = 64
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic undivided,
  // count enable pulse
  output logic tick
);
  logic [$clog2(DIV)-1:0] pre_reg;

  // free running prescaler; wraps at DIV
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
    end else if (ce) begin
      pre_reg <= (pre_reg == ($clog2(DIV))'(DIV - 1)) ? '0 : pre_reg + 1'b1;
    end
  end

  assign tick = ce && (undivided || pre_reg == ($clog2(DIV))'(DIV - 1));
endmodule : smtx_tick_gen
`default_nettype wire

// file: smtx_timeout_cnt.sv
// saturating duration counter with threshold compare
`timescale 1ns/1ps
`default_nettype none
module smtx_timeout_cnt #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // counting
  input wire logic tick,
  input wire logic active,
  input wire logic [W-1:0] limit,
  // level, true while the condition has lasted limit ticks
  output logic reached
);
  logic [W-1:0] cnt_reg;

  // restarts whenever the watched condition breaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (!active) cnt_reg <= '0;
      else if (tick && cnt_reg != '1) cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // a zero limit means disabled
  assign reached = active && (limit != '0) && (cnt_reg >= limit);
endmodule : smtx_timeout_cnt
`default_nettype wire

// file: smtx_core.sv
// smbus extension: fast ack, address matching, bus timeouts, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "smtx_regs.svh"
module smtx_core import smtx_pkg::*; #(
  parameter int TW = 16,
  parameter int AW = 18
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus line levels seen by the controller
  input wire logic scl_in,
  input wire logic sda_in,
  // from the core shifter
  input wire logic byte_received,
  input wire logic addr_valid,
  input wire logic [6:0] rx_addr,
  // to the core shifter
  output logic ack_strobe,
  output logic ack_nack,
  output logic second_addr_match,
  output logic alert_match,
  // interrupt
  output logic irq
);
  logic [7:0] ctrl_reg;
  logic [6:0] a2_reg;
  logic [7:0] slth_reg;
  logic [7:0] sltl_reg;
  logic transmit_acknowledge_control_reg;
  logic [2:0] irq_st_reg;
  logic [2:0] irq_msk_reg;
  logic bus_idle_timeout_flag_reg;
  logic [31:0] rdata_reg;
  logic ack_strobe_reg;
  logic ack_nack_reg;
  logic a2_match_reg;
  logic alert_match_reg;
  smtx_ack_state_type ack_state_reg;
  logic [TW-1:0] low_value;
  logic [TW-1:0] high_limit;
  logic [15:0] idx;
  logic mapped;
  logic setup;
  logic wr;
  logic tick;
  logic low_hit;
  logic idle_hit;
  logic hl_hit;
  logic low_hit_d;
  logic hl_hit_d;
  logic low_set;
  logic hl_set;
  logic idle_rise;
  logic [2:0] irq_set;

  // apb decode; word index is the byte address divided by four
  assign idx = paddr[17:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && ce;
  assign mapped = idx >= `SMTX_IDX_CTRL && idx <= `SMTX_IDX_IRQMSK;
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_reg;

  assign low_value = {slth_reg, sltl_reg};
  assign high_limit = low_value >> `SMTX_HIGH_SHIFT;

  // timeout counter clock
  smtx_tick_gen #(.DIV(`SMTX_PRESCALE)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .undivided(ctrl_reg[`SMTX_B_TIMEOUT_CLOCK_SELECT]),
    .tick(tick)
  );

  // scl low duration against the full value
  smtx_timeout_cnt #(.W(TW)) u_low (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .active(!scl_in),
    .limit(low_value),
    .reached(low_hit)
  );

  // both lines high: bus free
  smtx_timeout_cnt #(.W(TW)) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .active(scl_in && sda_in),
    .limit(high_limit),
    .reached(idle_hit)
  );

  // scl high, sda low: stuck data line
  smtx_timeout_cnt #(.W(TW)) u_hl (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .active(scl_in && !sda_in),
    .limit(high_limit),
    .reached(hl_hit)
  );

  // edge detect so a held timeout re-flags only once per event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_hit_d <= 1'b0;
      hl_hit_d <= 1'b0;
      bus_idle_timeout_flag_reg <= 1'b0;
    end else if (ce) begin
      low_hit_d <= low_hit;
      hl_hit_d <= hl_hit;
      bus_idle_timeout_flag_reg <= idle_hit;
    end
  end
  assign low_set = low_hit && !low_hit_d;
  assign hl_set = hl_hit && !hl_hit_d;
  assign idle_rise = idle_hit && !bus_idle_timeout_flag_reg;

  // control bits and timeout value; flags: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SMTX_RST_BYTE;
      a2_reg <= '0;
      slth_reg <= `SMTX_RST_BYTE;
      sltl_reg <= `SMTX_RST_BYTE;
    end else if (ce) begin
      if (wr && idx == `SMTX_IDX_CTRL) begin
        ctrl_reg[7:4] <= pwdata[7:4];
        ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_IRQ_ENABLE] <= pwdata[`SMTX_B_CLOCK_HIGH_DATA_LOW_IRQ_ENABLE];
      end
      ctrl_reg[`SMTX_B_CLOCK_LOW_TIMEOUT_FLAG] <= low_set || (ctrl_reg[`SMTX_B_CLOCK_LOW_TIMEOUT_FLAG] &&
        !(wr && idx == `SMTX_IDX_CTRL && pwdata[`SMTX_B_CLOCK_LOW_TIMEOUT_FLAG]));
      ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG] <= hl_set || (ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG] &&
        !(wr && idx == `SMTX_IDX_CTRL && pwdata[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG]));
      ctrl_reg[`SMTX_B_BUS_IDLE_TIMEOUT_FLAG] <= 1'b0;
      if (wr && idx == `SMTX_IDX_A2) a2_reg <= pwdata[7:1];
      if (wr && idx == `SMTX_IDX_SLTH) slth_reg <= pwdata[7:0];
      if (wr && idx == `SMTX_IDX_SLTL) sltl_reg <= pwdata[7:0];
    end
  end

  // interrupt status, sticky, write one to clear, set wins
  assign irq_set = {idle_rise, hl_set, low_set};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= `SMTX_RST_IRQ;
      irq_msk_reg <= `SMTX_RST_IRQ;
    end else if (ce) begin
      irq_st_reg <= irq_set | (irq_st_reg &
        ~((wr && idx == `SMTX_IDX_IRQST) ? pwdata[2:0] : 3'h0));
      if (wr && idx == `SMTX_IDX_IRQMSK) irq_msk_reg <= pwdata[2:0];
    end
  end

  // flag path gated by its own enable, others through the mask
  assign irq = (ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG] && ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_IRQ_ENABLE]) ||
    |(irq_st_reg & irq_msk_reg);

  // acknowledge control; in fast mode a write after a byte releases the ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_acknowledge_control_reg <= 1'b0;
      ack_state_reg <= SMTX_ACK_IDLE;
      ack_strobe_reg <= 1'b0;
      ack_nack_reg <= 1'b0;
    end else if (ce) begin
      ack_strobe_reg <= 1'b0;
      if (wr && idx == `SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL) transmit_acknowledge_control_reg <= pwdata[0];
      case (ack_state_reg)
        SMTX_ACK_IDLE: begin
          if (byte_received && ctrl_reg[`SMTX_B_FAST_ACK_MODE]) begin
            ack_state_reg <= SMTX_ACK_WAIT;
          end else if (byte_received) begin
            ack_strobe_reg <= 1'b1;
            ack_nack_reg <= transmit_acknowledge_control_reg;
          end
        end
        SMTX_ACK_WAIT: begin
          if (wr && idx == `SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL) begin
            ack_strobe_reg <= 1'b1;
            ack_nack_reg <= pwdata[0];
            ack_state_reg <= SMTX_ACK_IDLE;
          end
        end
        default: ack_state_reg <= SMTX_ACK_IDLE;
      endcase
    end
  end
  assign ack_strobe = ack_strobe_reg;
  assign ack_nack = ack_nack_reg;

  // address compare on each received address; software answers alerts itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a2_match_reg <= 1'b0;
      alert_match_reg <= 1'b0;
    end else if (ce) begin
      a2_match_reg <= addr_valid && ctrl_reg[`SMTX_B_A2EN] && rx_addr == a2_reg;
      alert_match_reg <= addr_valid && ctrl_reg[`SMTX_B_ALERT_RESPONSE_ENABLE] &&
        rx_addr == `SMTX_ALERT_ADDR;
    end
  end
  assign second_addr_match = a2_match_reg;
  assign alert_match = alert_match_reg;

  // read data staged in the setup phase so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
    end else if (ce && setup) begin
      case (idx)
        `SMTX_IDX_CTRL: rdata_reg <= {24'h000000, ctrl_reg[7:3], bus_idle_timeout_flag_reg, ctrl_reg[1:0]};
        `SMTX_IDX_A2: rdata_reg <= {24'h000000, a2_reg, 1'b0};
        `SMTX_IDX_SLTH: rdata_reg <= {24'h000000, slth_reg};
        `SMTX_IDX_SLTL: rdata_reg <= {24'h000000, sltl_reg};
        `SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL: rdata_reg <= {30'h00000000, ack_state_reg == SMTX_ACK_WAIT, transmit_acknowledge_control_reg};
        `SMTX_IDX_IRQST: rdata_reg <= {29'h00000000, irq_st_reg};
        `SMTX_IDX_IRQMSK: rdata_reg <= {29'h00000000, irq_msk_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  // checks
  property p_fast_ack_mode_next;
    @(posedge pclk) disable iff (!presetn)
    ce && byte_received && !ctrl_reg[`SMTX_B_FAST_ACK_MODE] && ack_state_reg == SMTX_ACK_IDLE
      |=> ack_strobe && ack_nack == $past(transmit_acknowledge_control_reg);
  endproperty
  a_fast_ack_mode_next: assert property (p_fast_ack_mode_next) else $error("ack not sent for next byte");

  property p_fast_ack_mode_hold;
    @(posedge pclk) disable iff (!presetn)
    ce && byte_received && ctrl_reg[`SMTX_B_FAST_ACK_MODE] && ack_state_reg == SMTX_ACK_IDLE
      |=> !ack_strobe;
  endproperty
  a_fast_ack_mode_hold: assert property (p_fast_ack_mode_hold) else $error("fast ack sent early");

  property p_alert;
    @(posedge pclk) disable iff (!presetn)
    ce && addr_valid |=> alert_match ==
      ($past(ctrl_reg[`SMTX_B_ALERT_RESPONSE_ENABLE]) && $past(rx_addr) == `SMTX_ALERT_ADDR);
  endproperty
  a_alert: assert property (p_alert) else $error("alert match wrong");

  property p_second;
    @(posedge pclk) disable iff (!presetn)
    ce && addr_valid && !ctrl_reg[`SMTX_B_A2EN] |=> !second_addr_match;
  endproperty
  a_second: assert property (p_second) else $error("second address matched while off");

  property p_div;
    @(posedge pclk) disable iff (!presetn)
    tick && !ctrl_reg[`SMTX_B_TIMEOUT_CLOCK_SELECT] && ce |=> (!tick || ctrl_reg[`SMTX_B_TIMEOUT_CLOCK_SELECT]) [*8];
  endproperty
  a_div: assert property (p_div) else $error("divided tick too fast");

  property p_low_set;
    @(posedge pclk) disable iff (!presetn)
    ce && low_set |=> ctrl_reg[`SMTX_B_CLOCK_LOW_TIMEOUT_FLAG] && irq_st_reg[`SMTX_IRQ_LOW];
  endproperty
  a_low_set: assert property (p_low_set) else $error("low timeout flag missed");

  property p_low_off;
    @(posedge pclk) disable iff (!presetn)
    ce && low_value == '0 && !ctrl_reg[`SMTX_B_CLOCK_LOW_TIMEOUT_FLAG] |=> !ctrl_reg[`SMTX_B_CLOCK_LOW_TIMEOUT_FLAG];
  endproperty
  a_low_off: assert property (p_low_off) else $error("low timeout with zero value");

  property p_idle;
    @(posedge pclk) disable iff (!presetn)
    ce && !(scl_in && sda_in) |=> !bus_idle_timeout_flag_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag held on busy bus");

  property p_hl;
    @(posedge pclk) disable iff (!presetn)
    ce && hl_set |=> ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG];
  endproperty
  a_hl: assert property (p_hl) else $error("high low flag missed");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG] && !ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_IRQ_ENABLE] && (irq_st_reg & irq_msk_reg) == 3'h0
      |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");

  property p_irq_on;
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_TIMEOUT_FLAG] && ctrl_reg[`SMTX_B_CLOCK_HIGH_DATA_LOW_IRQ_ENABLE] |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

  property p_a2_lsb;
    @(posedge pclk) disable iff (!presetn)
    ce && setup && idx == `SMTX_IDX_A2 |=> prdata[0] == 1'b0;
  endproperty
  a_a2_lsb: assert property (p_a2_lsb) else $error("address bit 0 not zero");

  property p_slth;
    @(posedge pclk) disable iff (!presetn)
    wr && idx == `SMTX_IDX_SLTH |=> low_value[15:8] == $past(pwdata[7:0]);
  endproperty
  a_slth: assert property (p_slth) else $error("high byte not in value");

  c_low: cover property (@(posedge pclk) disable iff (!presetn) low_set);
  c_hl_irq: cover property (@(posedge pclk) disable iff (!presetn) hl_set ##1 irq);
  c_fast_ack_mode: cover property (@(posedge pclk) disable iff (!presetn)
    ack_state_reg == SMTX_ACK_WAIT ##[1:50] ack_strobe);
  c_alert: cover property (@(posedge pclk) disable iff (!presetn) alert_match);
endmodule : smtx_core
`default_nettype wire

// file: smtx_bus_model.sv
// behavioural model of the smbus lines and the core shifter events
`timescale 1ns/1ps
`default_nettype none
module smtx_bus_model (
  // clock
  input wire logic pclk,
  // bus line levels
  output logic scl,
  output logic sda,
  // shifter events
  output logic byte_received,
  output logic addr_valid,
  output logic [6:0] rx_addr
);
  // pull-ups keep both lines high while nobody drives them
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    byte_received = 1'b0;
    addr_valid = 1'b0;
    rx_addr = 7'h7F;
  end
  // lines change right after an edge and keep their level until told
  task automatic set_lines(input logic s, input logic d);
    @(posedge pclk);
    scl <= s;
    sda <= d;
  endtask : set_lines
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // one-cycle pulse of a received data byte
  task automatic pulse_byte;
    @(posedge pclk);
    byte_received <= 1'b1;
    @(posedge pclk);
    byte_received <= 1'b0;
  endtask : pulse_byte
  // address is only valid with its strobe; it is scrambled afterwards
  task automatic send_addr(input logic [6:0] a);
    @(posedge pclk);
    addr_valid <= 1'b1;
    rx_addr <= a;
    @(posedge pclk);
    addr_valid <= 1'b0;
    rx_addr <= ~a;
  endtask : send_addr
endmodule : smtx_bus_model
`default_nettype wire

// file: smtx_core_tb_top.sv
// self-checking bench of the smbus extension block
`timescale 1ns/1ps
`default_nettype none
`include "smtx_regs.svh"
module smtx_core_tb_top;
  // stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err_seen, scl, sda, byte_rx, addr_v;
  logic ack_strobe, ack_nack, a2_hit, alert_hit, irq;
  logic [6:0] rx_addr;
  int errors = 0;
  int checked = 0;
  // 25 MHz clock
  always #20 pclk = ~pclk;
  smtx_core i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .byte_received(byte_rx),
    .addr_valid(addr_v), .rx_addr(rx_addr), .ack_strobe(ack_strobe), .ack_nack(ack_nack),
    .second_addr_match(a2_hit), .alert_match(alert_hit), .irq(irq));
  smtx_bus_model i_bus (.pclk(pclk), .scl(scl), .sda(sda), .byte_received(byte_rx),
    .addr_valid(addr_v), .rx_addr(rx_addr));
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // reset values and an unmapped word
  task automatic t_reset;
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, `SMTX_IDX_SLTL, 8'h00);
    chk("low byte reset", 32'h0, rd);
    apb(1'b0, 16'h3070, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
  endtask : t_reset
  // second address and alert address matching
  task automatic t_addr;
    apb(1'b1, `SMTX_IDX_A2, 8'h55);
    apb(1'b0, `SMTX_IDX_A2, 8'h00);
    chk("a2 readback", 32'h54, rd);
    i_bus.send_addr(7'h2A);
    #1 chk("a2 off", 32'h0, {31'h0, a2_hit});
    apb(1'b1, `SMTX_IDX_CTRL, 8'h20);
    i_bus.send_addr(7'h2A);
    #1 chk("a2 on", 32'h1, {31'h0, a2_hit});
    i_bus.send_addr(7'h0C);
    #1 chk("alert off", 32'h0, {31'h0, alert_hit});
    apb(1'b1, `SMTX_IDX_CTRL, 8'h40);
    i_bus.send_addr(7'h0C);
    #1 chk("alert on", 32'h1, {31'h0, alert_hit});
  endtask : t_addr
  // clock enable low: no ready, address events ignored, a write waits for it
  task automatic t_ce;
    @(posedge pclk);
    ce <= 1'b0;
    i_bus.send_addr(7'h0C);
    #1 chk("ce ready", 32'h0, {31'h0, pready});
    chk("ce frozen", 32'h0, {31'h0, alert_hit});
    fork
      apb(1'b1, `SMTX_IDX_A2, 8'h33);
      begin
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, `SMTX_IDX_A2, 8'h00);
    chk("ce write", 32'h32, rd);
  endtask : t_ce
  // ack choice before the byte, then written after the byte in fast mode
  task automatic t_ack;
    apb(1'b1, `SMTX_IDX_CTRL, 8'h00);
    apb(1'b1, `SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL, 8'h01);
    i_bus.pulse_byte();
    #1 chk("slow ack", 32'h3, {30'h0, ack_strobe, ack_nack});
    apb(1'b1, `SMTX_IDX_CTRL, 8'h80);
    i_bus.pulse_byte();
    #1 chk("fast waits", 32'h0, {31'h0, ack_strobe});
    apb(1'b0, `SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL, 8'h00);
    chk("ack pending", 32'h3, rd);
    apb(1'b1, `SMTX_IDX_TRANSMIT_ACKNOWLEDGE_CONTROL, 8'h00);
    #1 chk("fast ack", 32'h2, {30'h0, ack_strobe, ack_nack});
  endtask : t_ack
  // value 0x0400: low limit 1024 ticks, high limits 2 ticks
  task automatic t_timeout;
    apb(1'b1, `SMTX_IDX_SLTH, 8'h04);
    apb(1'b1, `SMTX_IDX_SLTL, 8'h00);
    apb(1'b1, `SMTX_IDX_CTRL, 8'h11);
    i_bus.set_lines(1'b1, 1'b0);
    i_bus.idle(10);
    i_bus.set_lines(1'b1, 1'b1);
    i_bus.idle(4);
    #1 chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("hl and idle flags", 32'h17, rd);
    apb(1'b1, `SMTX_IDX_CTRL, 8'h10);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `SMTX_IDX_CTRL, 8'h13);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    i_bus.set_lines(1'b0, 1'b1);
    i_bus.idle(3);
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("idle drops", 32'h11, rd);
    i_bus.idle(1100);
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("low flag", 32'h19, rd);
    apb(1'b1, `SMTX_IDX_CTRL, 8'h19);
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("low cleared", 32'h11, rd & 32'hFB);
    apb(1'b1, `SMTX_IDX_SLTH, 8'h00);
    i_bus.set_lines(1'b1, 1'b1);
    i_bus.set_lines(1'b0, 1'b1);
    i_bus.idle(1100);
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("low disabled", 32'h11, rd);
    apb(1'b1, `SMTX_IDX_SLTH, 8'h04);
    apb(1'b1, `SMTX_IDX_CTRL, 8'h08);
    i_bus.set_lines(1'b1, 1'b0);
    i_bus.idle(40);
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("divided early", 32'h0, rd & 32'h2);
    i_bus.idle(120);
    apb(1'b0, `SMTX_IDX_CTRL, 8'h00);
    chk("divided late", 32'h2, rd & 32'h2);
  endtask : t_timeout
  // event status and mask registers behind the interrupt line
  task automatic t_irq;
    apb(1'b0, `SMTX_IDX_IRQST, 8'h00);
    chk("event status", 32'h7, rd);
    apb(1'b1, `SMTX_IDX_IRQMSK, 8'h02);
    #1 chk("irq via mask", 32'h1, {31'h0, irq});
    apb(1'b1, `SMTX_IDX_IRQST, 8'h02);
    #1 chk("irq status cleared", 32'h0, {31'h0, irq});
    apb(1'b0, `SMTX_IDX_IRQST, 8'h00);
    chk("event status left", 32'h5, rd);
  endtask : t_irq
  // main sequence after 8 cycles of reset
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_addr();
    t_ce();
    t_ack();
    t_timeout();
    t_irq();
    give_verdict();
  end
  // watchdog, far beyond the ~2500 cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule : smtx_core_tb_top
`default_nettype wire
